// file: shared/srss_pkg.sv
// Contract
// R1: each strap pulse is at least 2 us wide and continuous pulsing repeats no faster than every 50 ms.
// R2: a strap pulse drives one direction only, with no opposite drive while it decays.
// R3: full compensation starts with a set pulse, then samples and stores the set-polarity reading.
// R4: it then gives an opposite reset pulse, samples and stores the reset-polarity reading.
// R5: the compensated field is half of the set reading minus the reset reading.
// R6: set and reset drives are never active together and a dead time separates them.
// R7: set and reset controls come from this controller and steer complementary driver switches.
// R8: in single-clock mode one trigger requests set on its rising and reset on its falling edge.
// R9: in single-clock mode the trigger stays high and low for at least 25 us each.
// R10: occasional mode pulses reset only at power-on or after an out-of-range reading.
// R11: low-power mode applies set then reset and computes the offset term as half their sum.
// R12: low-power mode stores the offset term and subtracts it from every later reading.
// R13: an interval timer reruns the low-power offset update about every 10 minutes.
// R14: a programmable settling wait follows each pulse and the result is valid only at sequence end.
// R15: readings outside programmable limits raise a status flag and a reset request.
package srss_pkg;

	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned CLK_NS = 10;
	localparam int unsigned PULSE_NS = 2000;
	localparam int unsigned PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned DEAD_NS = 100;
	localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TRIG_HOLD_US = 25;
	localparam int unsigned TRIG_HOLD_CYC =
		(TRIG_HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int unsigned REPEAT_MS = 50;
	localparam int unsigned REPEAT_CYC = REPEAT_MS * (CLK_HZ / 1000);
	localparam longint unsigned OFFS_UPD_MIN = 10;
	localparam longint unsigned OFFS_UPD_CYC =
		OFFS_UPD_MIN * 64'd60 * CLK_HZ;
	localparam logic POWER_ON_RST = 1'b1;

	typedef enum logic [1:0] {MODE_CONT, MODE_CLOCK, MODE_OCC, MODE_LOWPWR}
		srss_mode_t;
	typedef enum logic [1:0] {SEQ_FULL, SEQ_RST, SEQ_PLAIN} srss_seq_t;
	typedef enum logic [3:0] {ST_IDLE, ST_DEAD_SET, ST_PULSE_SET,
		ST_SETTLE_SET, ST_SAMP_SET, ST_HOLD_RST, ST_DEAD_RST, ST_PULSE_RST,
		ST_SETTLE_RST, ST_SAMP_RST, ST_SAMP_PLAIN, ST_DONE} srss_state_t;

endpackage : srss_pkg

// file: rtl/srss_strap_seq.sv
`timescale 1ns/1ps
module srss_strap_seq
	import srss_pkg::*;
#(
	parameter int DW = 16,
	parameter int unsigned INTERVAL_CYC = REPEAT_CYC,
	parameter longint unsigned OFFS_CYC = OFFS_UPD_CYC
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire srss_mode_t mode,
	input wire logic [15:0] settleCycles,
	input wire logic signed [DW-1:0] upperLimit,
	input wire logic signed [DW-1:0] lowerLimit,
	input wire logic rangeClr,
	input wire logic sampleAck,
	input wire logic signed [DW-1:0] sampleData,
	output logic setDrive_r,
	output logic resetDrive_r,
	output logic trig_r,
	output logic sampleReq_r,
	output logic signed [DW-1:0] fieldOut_r,
	output logic signed [DW-1:0] offsetTerm_r,
	output logic resultValid_r,
	output logic outOfRange_r,
	output logic rangeResetReq_r
);

	srss_state_t state_r;
	srss_seq_t seq_r;
	srss_mode_t modeCur_r;
	logic [31:0] cnt_r;
	logic [31:0] ivCnt_r;
	logic [39:0] offsCnt_r;
	logic [31:0] trigAge_r;
	logic tickPend_r;
	logic offsDue_r;
	logic powerOn_r;
	logic rangePend_r;
	logic signed [DW-1:0] vset_r;
	logic signed [DW-1:0] vrst_r;
	logic start;
	srss_seq_t kind;
	logic capture;
	logic trigOk;
	logic holdOk;
	logic trigRise;
	logic trigFall;
	logic outside;
	logic signed [DW:0] diffW;
	logic signed [DW:0] sumW;

	assign capture = sampleReq_r && sampleAck;
	assign trigOk = trigAge_r >= TRIG_HOLD_CYC;
	assign holdOk = (modeCur_r != MODE_CLOCK) || trigOk;
	assign outside = (sampleData > upperLimit) || (sampleData < lowerLimit);
	assign diffW = {vset_r[DW-1], vset_r} - {vrst_r[DW-1], vrst_r};
	assign sumW = {vset_r[DW-1], vset_r} + {vrst_r[DW-1], vrst_r};
	assign trigRise = start && (kind == SEQ_FULL) && (mode == MODE_CLOCK);
	assign trigFall = (state_r == ST_HOLD_RST) && trig_r && holdOk;

	// what to run when idle; the trigger gap also gates starts in clock mode
	always_comb
	begin
		start = 1'b0;
		kind = SEQ_PLAIN;
		if (state_r == ST_IDLE && (mode != MODE_CLOCK || trigOk))
		begin
			unique case (mode)
				MODE_CONT, MODE_CLOCK:
				begin
					start = tickPend_r; // R1
					kind = SEQ_FULL;
				end
				MODE_OCC:
				begin
					start = powerOn_r || rangePend_r || tickPend_r; // R10
					kind = (powerOn_r || rangePend_r) ? SEQ_RST : SEQ_PLAIN;
				end
				MODE_LOWPWR:
				begin
					start = powerOn_r || offsDue_r || tickPend_r; // R13
					kind = (powerOn_r || offsDue_r) ? SEQ_FULL : SEQ_PLAIN;
				end
			endcase
		end
	end

	// repeat interval; a larger parameter lowers pulse power in continuous and clock modes and also the reading rate in every mode
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ivCnt_r <= '0;
			tickPend_r <= 1'b0;
		end
		else
		begin
			if (ivCnt_r == INTERVAL_CYC - 1)
				ivCnt_r <= '0;
			else
				ivCnt_r <= ivCnt_r + 32'h1;
			if (ivCnt_r == INTERVAL_CYC - 1)
				tickPend_r <= 1'b1; // R1
			else if (start)
				tickPend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			offsCnt_r <= '0;
			offsDue_r <= 1'b0;
			powerOn_r <= POWER_ON_RST;
			rangePend_r <= 1'b0;
		end
		else
		begin
			if (offsCnt_r == 40'(OFFS_CYC - 1))
				offsCnt_r <= '0;
			else
				offsCnt_r <= offsCnt_r + 40'h1;
			if (offsCnt_r == 40'(OFFS_CYC - 1))
				offsDue_r <= 1'b1; // R13
			else if (start && kind == SEQ_FULL)
				offsDue_r <= 1'b0;
			if (start && kind != SEQ_PLAIN)
				powerOn_r <= 1'b0;
			if (capture && outside)
				rangePend_r <= 1'b1; // R10
			else if (start && kind == SEQ_RST)
				rangePend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			trig_r <= 1'b0;
			trigAge_r <= TRIG_HOLD_CYC;
		end
		else
		begin
			if (trigRise)
				trig_r <= 1'b1; // R8
			else if (trigFall)
				trig_r <= 1'b0; // R8
			if (trigRise || trigFall)
				trigAge_r <= '0;
			else if (!trigOk)
				trigAge_r <= trigAge_r + 32'h1; // R9
		end
	end

	// drives are high exactly while in a pulse state; dead states keep both low
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_r <= ST_IDLE;
			seq_r <= SEQ_PLAIN;
			modeCur_r <= MODE_CONT;
			cnt_r <= '0;
			setDrive_r <= 1'b0;
			resetDrive_r <= 1'b0;
			sampleReq_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_r + 32'h1;
			unique case (state_r)
				ST_IDLE:
				begin
					cnt_r <= '0;
					if (start)
					begin
						modeCur_r <= mode;
						seq_r <= kind;
						if (kind == SEQ_RST)
							state_r <= ST_DEAD_RST; // R10
						else if (kind == SEQ_PLAIN)
						begin
							state_r <= ST_SAMP_PLAIN;
							sampleReq_r <= 1'b1;
						end
						else
							state_r <= ST_DEAD_SET; // R3
					end
				end
				ST_DEAD_SET:
					if (cnt_r == DEAD_CYC - 1)
					begin
						state_r <= ST_PULSE_SET;
						cnt_r <= '0;
						setDrive_r <= 1'b1; // R6 R7
					end
				ST_PULSE_SET:
					if (cnt_r == PULSE_CYC - 1)
					begin
						state_r <= ST_SETTLE_SET;
						cnt_r <= '0;
						setDrive_r <= 1'b0; // R1 R2
					end
				ST_SETTLE_SET:
					if (cnt_r >= 32'(settleCycles))
					begin
						state_r <= ST_SAMP_SET; // R14
						sampleReq_r <= 1'b1;
					end
				ST_SAMP_SET:
					if (capture)
					begin
						state_r <= ST_HOLD_RST; // R4
						sampleReq_r <= 1'b0;
					end
				ST_HOLD_RST:
					if (holdOk)
					begin
						state_r <= ST_DEAD_RST;
						cnt_r <= '0;
					end
				ST_DEAD_RST:
					if (cnt_r == DEAD_CYC - 1)
					begin
						state_r <= ST_PULSE_RST;
						cnt_r <= '0;
						resetDrive_r <= 1'b1; // R6 R7
					end
				ST_PULSE_RST:
					if (cnt_r == PULSE_CYC - 1)
					begin
						state_r <= ST_SETTLE_RST;
						cnt_r <= '0;
						resetDrive_r <= 1'b0; // R1 R2
					end
				ST_SETTLE_RST:
					if (cnt_r >= 32'(settleCycles))
					begin
						state_r <= ST_SAMP_RST; // R14
						sampleReq_r <= 1'b1;
					end
				ST_SAMP_RST, ST_SAMP_PLAIN:
					if (capture)
					begin
						state_r <= ST_DONE;
						sampleReq_r <= 1'b0;
					end
				ST_DONE:
					state_r <= ST_IDLE;
			endcase
		end
	end

	// low-power subtraction wraps on overflow rather than saturating
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			vset_r <= '0;
			vrst_r <= '0;
			fieldOut_r <= '0;
			offsetTerm_r <= '0;
			resultValid_r <= 1'b0;
		end
		else
		begin
			resultValid_r <= (state_r == ST_DONE); // R14
			if (capture && state_r == ST_SAMP_SET)
				vset_r <= sampleData; // R3
			if (capture && state_r == ST_SAMP_RST)
				vrst_r <= sampleData; // R4
			if (capture && state_r == ST_SAMP_PLAIN)
			begin
				if (modeCur_r == MODE_LOWPWR)
					fieldOut_r <= sampleData - offsetTerm_r; // R12
				else
					fieldOut_r <= sampleData;
			end
			if (state_r == ST_DONE && seq_r == SEQ_FULL)
			begin
				if (modeCur_r == MODE_LOWPWR)
					offsetTerm_r <= sumW[DW:1]; // R11
				else
					fieldOut_r <= diffW[DW:1]; // R5
			end
			if (state_r == ST_DONE && seq_r == SEQ_RST)
				fieldOut_r <= vrst_r;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			outOfRange_r <= 1'b0;
			rangeResetReq_r <= 1'b0;
		end
		else
		begin
			rangeResetReq_r <= capture && outside; // R15
			if (capture && outside)
				outOfRange_r <= 1'b1; // R15
			else if (rangeClr)
				outOfRange_r <= 1'b0;
		end
	end

	logic [31:0] setHi;
	logic [31:0] rstHi;
	logic [31:0] lowCnt;
	always_ff @(posedge clk)
	begin
		setHi <= setDrive_r ? setHi + 32'h1 : '0;
		rstHi <= resetDrive_r ? rstHi + 32'h1 : '0;
		lowCnt <= (setDrive_r || resetDrive_r) ? '0 : lowCnt + 32'h1;
		if (!resetn)
			lowCnt <= DEAD_CYC;
	end

	a_drive_exclusive: assert property (@(posedge clk) disable iff (!resetn) // R6
		!(setDrive_r && resetDrive_r)) else $error("set and reset both on");
	a_set_width: assert property (@(posedge clk) disable iff (!resetn) // R1
		$fell(setDrive_r) |-> setHi == PULSE_CYC) else $error("set width");
	a_reset_width: assert property (@(posedge clk) disable iff (!resetn) // R1
		$fell(resetDrive_r) |-> rstHi == PULSE_CYC) else $error("reset width");
	a_dead_gap: assert property (@(posedge clk) disable iff (!resetn) // R6
		($rose(setDrive_r) || $rose(resetDrive_r)) |-> lowCnt >= DEAD_CYC)
		else $error("dead time too short");
	a_trig_hold: assert property (@(posedge clk) disable iff (!resetn) // R9
		$changed(trig_r) |-> $past(trigAge_r) >= TRIG_HOLD_CYC)
		else $error("trigger edge too early");
	a_trig_set_edge: assert property (@(posedge clk) disable iff (!resetn) // R8
		$rose(trig_r) |-> state_r == ST_DEAD_SET && !setDrive_r)
		else $error("set not after trigger rise");
	a_req_held: assert property (@(posedge clk) disable iff (!resetn) // R14
		sampleReq_r && !sampleAck |=> sampleReq_r) else $error("req dropped");
	a_valid_at_end: assert property (@(posedge clk) disable iff (!resetn) // R14
		resultValid_r |-> $past(state_r) == ST_DONE && state_r == ST_IDLE)
		else $error("valid not at end");
	a_occ_no_set: assert property (@(posedge clk) disable iff (!resetn) // R10
		setDrive_r |-> modeCur_r != MODE_OCC) else $error("set in occasional");
	a_range_flag: assert property (@(posedge clk) disable iff (!resetn) // R15
		capture && outside |=> outOfRange_r && rangeResetReq_r)
		else $error("range not flagged");
	a_field_half: assert property (@(posedge clk) disable iff (!resetn) // R5
		resultValid_r && seq_r == SEQ_FULL && modeCur_r != MODE_LOWPWR
		|-> fieldOut_r == diffW[DW:1]) else $error("field not half diff");
	a_offset_half: assert property (@(posedge clk) disable iff (!resetn) // R11
		resultValid_r && seq_r == SEQ_FULL && modeCur_r == MODE_LOWPWR
		|-> offsetTerm_r == sumW[DW:1]) else $error("offset not half sum");

endmodule : srss_strap_seq

// file: dv/srss_conv_model.sv
`timescale 1ns/1ps
module srss_conv_model
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic sampleReq,
	input wire logic setDrive,
	input wire logic resetDrive,
	input wire logic [3:0] dly,
	input wire logic signed [15:0] valSet,
	input wire logic signed [15:0] valRst,
	output logic sampleAck,
	output logic signed [15:0] sampleData
);
	logic pol;
	logic [3:0] cnt;
	// bridge polarity follows the last strap pulse
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			sampleAck <= 1'b0;
			cnt <= 4'h0;
			pol <= 1'b0;
			sampleData <= 16'sh0;
		end
		else
		begin
			if (setDrive)
				pol <= 1'b1;
			if (resetDrive)
				pol <= 1'b0;
			if (sampleReq && !sampleAck && cnt >= dly)
			begin
				sampleAck <= 1'b1;
				sampleData <= pol ? valSet : valRst;
				cnt <= 4'h0;
			end
			else
			begin
				sampleAck <= 1'b0;
				// stale data toggles so it never passes for a reading
				sampleData <= ~sampleData;
				if (sampleReq && !sampleAck)
					cnt <= cnt + 4'h1;
			end
		end
	end
endmodule : srss_conv_model

// file: dv/set_reset_strap_sequencer_bench.sv
`timescale 1ns/1ps
module set_reset_strap_sequencer_bench
	import srss_pkg::*;
;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	srss_mode_t mode = MODE_CONT;
	logic [15:0] settle = 16'h0;
	logic rangeClr = 1'b0;
	logic [3:0] dly = 4'h0;
	logic signed [15:0] vS = 16'sh0, vR = 16'sh0, off;
	logic sAck, setD, rstD, trig, req, rv, oor, rrq;
	logic signed [15:0] sData, fOut, oTerm;
	logic pSet, pRst, pRv, pTrig;
	int n_fail = 0, checked = 0, seed = 32'h5389d38d;
	int nSet, nRst, sLen, rLen, gap, tHi, tLo, cyc, c0, k;
	// loop count kept apart from k, which wait_ev reuses for its timeout
	int nw;
	logic signed [15:0] upLim = 16'sh2000;
	logic signed [15:0] loLim = 16'she000;

	always #5 clk = ~clk;

	srss_strap_seq #(.INTERVAL_CYC(1000), .OFFS_CYC(5000)) i_dut (
		.clk(clk), .resetn(resetn), .mode(mode), .settleCycles(settle),
		.upperLimit(upLim), .lowerLimit(loLim),
		.rangeClr(rangeClr), .sampleAck(sAck), .sampleData(sData),
		.setDrive_r(setD), .resetDrive_r(rstD), .trig_r(trig),
		.sampleReq_r(req), .fieldOut_r(fOut), .offsetTerm_r(oTerm),
		.resultValid_r(rv), .outOfRange_r(oor), .rangeResetReq_r(rrq));

	srss_conv_model i_conv (.clk(clk), .resetn(resetn), .sampleReq(req),
		.setDrive(setD), .resetDrive(rstD), .dly(dly), .valSet(vS),
		.valRst(vR), .sampleAck(sAck), .sampleData(sData));

	task stop_test;
		$display("failures %0d checks %0d", n_fail, checked);
		if (n_fail == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test

	task chk_val(input logic signed [15:0] got, input logic signed [15:0] e);
		checked++;
		if (got !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t value %0d expected %0d", $time, got, e);
		end
	endtask : chk_val

	task chk_bit(input logic got, input logic e);
		checked++;
		if (got !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t flag %b expected %b", $time, got, e);
		end
	endtask : chk_bit

	function automatic logic signed [15:0] half(input logic signed [15:0] a,
		input logic signed [15:0] b, input logic sub);
		logic [16:0] t;
		t = sub ? {a[15], a} - {b[15], b} : {a[15], a} + {b[15], b};
		return t[16:1];
	endfunction : half

	// bounded wait for result pulse (0) or range request (1)
	task wait_ev(input int which);
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (!(which ? rrq === 1'b1 : rv === 1'b1) && k < 20000);
		if (k >= 20000)
			chk_bit(1'b0, 1'b1);
		#1;
	endtask : wait_ev

	task do_reset(input srss_mode_t m);
		@(posedge clk);
		#1;
		resetn = 1'b0;
		mode = m;
		vS = 16'($random(seed) % 8000);
		vR = 16'($random(seed) % 8000);
		settle = 16'({$random(seed)} % 8);
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
	endtask : do_reset

	always @(posedge clk)
	begin
		cyc++;
		if (!resetn)
		begin
			nSet = 0;
			nRst = 0;
			gap = 1000;
			tLo = TRIG_HOLD_CYC;
		end
		else
		begin
			if (setD && rstD)
				chk_bit(1'b1, 1'b0);
			if (req)
				chk_bit(setD | rstD, 1'b0);
			if (rv && pRv)
				chk_bit(1'b1, 1'b0);
			if (setD && !pSet)
			begin
				chk_bit(gap >= DEAD_CYC, 1'b1);
				if (mode == MODE_CLOCK)
					chk_bit(trig, 1'b1);
				nSet++;
			end
			if (rstD && !pRst)
			begin
				chk_bit(gap >= DEAD_CYC, 1'b1);
				if (mode == MODE_CLOCK)
					chk_bit(trig, 1'b0);
				nRst++;
			end
			if (pSet && !setD)
				chk_bit(sLen == PULSE_CYC, 1'b1);
			if (pRst && !rstD)
				chk_bit(rLen == PULSE_CYC, 1'b1);
			if (pTrig && !trig)
				chk_bit(tHi >= TRIG_HOLD_CYC, 1'b1);
			if (!pTrig && trig)
				chk_bit(tLo >= TRIG_HOLD_CYC, 1'b1);
		end
		sLen = setD ? sLen + 1 : 0;
		rLen = rstD ? rLen + 1 : 0;
		gap = (setD || rstD) ? 0 : gap + 1;
		tHi = trig ? tHi + 1 : 0;
		tLo = trig ? 0 : tLo + 1;
		pSet = setD;
		pRst = rstD;
		pRv = rv;
		pTrig = trig;
	end

	initial
	begin
		do_reset(MODE_CONT);
		wait_ev(0);
		chk_val(fOut, half(vS, vR, 1'b1));
		c0 = cyc;
		dly = 4'h9;
		wait_ev(0);
		chk_bit(cyc - c0 >= 1000, 1'b1);
		chk_val(fOut, half(vS, vR, 1'b1));
		do_reset(MODE_CLOCK);
		wait_ev(0);
		chk_val(fOut, half(vS, vR, 1'b1));
		do_reset(MODE_OCC);
		wait_ev(0);
		chk_val(fOut, vR);
		vR = 16'sh2100;
		wait_ev(1);
		chk_bit(oor, 1'b1);
		vR = 16'sh0100;
		nw = 0;
		while (nRst < 2 && nw < 5)
		begin
			wait_ev(0);
			nw++;
		end
		chk_val(fOut, vR);
		rangeClr = 1'b1;
		@(posedge clk);
		#1;
		rangeClr = 1'b0;
		@(posedge clk);
		#1;
		chk_bit(oor, 1'b0);
		chk_bit(nSet == 0 && nRst == 2, 1'b1);
		do_reset(MODE_LOWPWR);
		wait_ev(0);
		off = half(vS, vR, 1'b0);
		chk_val(oTerm, off);
		vR = 16'($random(seed) % 8000);
		wait_ev(0);
		chk_val(fOut, vR - off);
		chk_bit(oor, 1'b0);
		// raise the lower limit just above the reading to trip under-range
		loLim = vR + 16'sh1;
		wait_ev(1);
		chk_bit(oor, 1'b1);
		nw = 0;
		while (nSet < 2 && nw < 10)
		begin
			wait_ev(0);
			nw++;
		end
		chk_bit(nSet == 2, 1'b1);
		chk_val(oTerm, half(vS, vR, 1'b0));
		stop_test;
	end

	initial
	begin
		repeat (60000) @(posedge clk);
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		stop_test;
	end
endmodule : set_reset_strap_sequencer_bench
